// ---- design/idc_pkg.sv ----
/*
 * Shared constants and types of the instruction decoder core.
 * Assumes one clock (clk, 200 MHz) and a synchronous active-high reset.
 */
`default_nettype none
package idc_pkg;
	localparam int        PCW          = 12;
	localparam int        IW           = 13;
	localparam int        DW           = 8;
	localparam int        STACK_DEPTH  = 8;
	// Oscillator periods (clk cycles) per instruction cycle
	localparam int        OSC_PER_CYC  = 2;
	localparam logic [11:0] PC_RESET   = 12'h000;
	localparam logic [11:0] SOFT_VECTOR = 12'h001;
	localparam logic [7:0]  PRESC_RESET = 8'hBF;
	localparam logic [7:0]  STATUS_RESET = 8'h18;
	localparam logic [5:0]  ADDR_PC     = 6'h02;
	localparam logic [5:0]  ADDR_STATUS = 6'h03;
	// Debug register port offsets and reset value
	localparam logic [2:0]  DBG_CTRL   = 3'h0;
	localparam logic [2:0]  DBG_ACC    = 3'h1;
	localparam logic [2:0]  DBG_PCL    = 3'h2;
	localparam logic [2:0]  DBG_STATUS = 3'h3;
	localparam logic [2:0]  DBG_PCH    = 3'h4;
	localparam logic        RUN_RESET  = 1'b1;

	typedef logic [IW-1:0]  idc_instr_t;
	typedef logic [PCW-1:0] idc_pc_t;
	typedef logic [DW-1:0]  idc_data_t;

	typedef enum logic [3:0] {
		ALU_PASS, ALU_ADD, ALU_SUB, ALU_OR, ALU_AND, ALU_XOR, ALU_COM,
		ALU_INC, ALU_DEC, ALU_RRC, ALU_RLC, ALU_SWAP, ALU_DAA
	} idc_alu_op_t;

	typedef struct packed {
		logic [7:0] val;
		logic       z;
		logic       c;
		logic       dc;
	} idc_alu_res_t;

	typedef struct packed {
		logic [2:0] gp;
		logic       t;
		logic       p;
		logic       z;
		logic       dc;
		logic       c;
	} idc_flags_t;

	typedef struct packed {
		logic                       phase;
		idc_instr_t                 ir;
		idc_pc_t                    pc;
		idc_data_t                  acc;
		idc_flags_t                 st;
		logic                       ie;
		idc_data_t                  presc;
		logic                       sleep;
		logic                       skip;
		logic                       bubble;
		logic                       run;
		logic                       reg_we;
		logic [5:0]                 reg_waddr;
		idc_data_t                  reg_wdata;
		logic                       ctl_we;
		logic [3:0]                 ctl_waddr;
		idc_data_t                  ctl_wdata;
		logic                       wdt_clr;
		idc_data_t                  rdata;
		logic [2:0]                 wake_sync;
	} idc_core_t;

	typedef struct packed {
		logic [STACK_DEPTH-1:0][PCW-1:0] slot;
		logic [2:0]                      ptr;
	} idc_stack_t;
endpackage : idc_pkg
`default_nettype wire

// ---- design/idc_alu.sv ----
/*
 * Combinational 8-bit ALU of the decoder core.
 * Assumes operands settle within one clk cycle.
 */
`default_nettype none
module idc_alu (
	// Operation and operands
	input  wire idc_pkg::idc_alu_op_t op,
	input  wire idc_pkg::idc_data_t   a,
	input  wire idc_pkg::idc_data_t   b,
	input  wire logic                 cin,
	input  wire logic                 dcin,
	// Result with flags
	output idc_pkg::idc_alu_res_t     res
);
	import idc_pkg::*;
	logic [8:0] sum;
	logic [8:0] adj;

	// Arithmetic and logic selection
	always_comb begin
		sum = 9'h000;
		adj = {1'b0, a};
		res = '{val: 8'h00, z: 1'b0, c: cin, dc: dcin};
		case (op)
		ALU_ADD: begin
			sum = {1'b0, a} + {1'b0, b};
			res.val = sum[7:0];
			res.c = sum[8];
			res.dc = ({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'h0F;
		end
		ALU_SUB: begin
			sum = {1'b0, b} - {1'b0, a}; // Operand minus accumulator
			res.val = sum[7:0];
			res.c = ~sum[8];             // Carry set when no borrow
			res.dc = b[3:0] >= a[3:0];
		end
		ALU_OR:   res.val = a | b;
		ALU_AND:  res.val = a & b;
		ALU_XOR:  res.val = a ^ b;
		ALU_COM:  res.val = ~b;
		ALU_INC:  res.val = b + 8'h01;
		ALU_DEC:  res.val = b - 8'h01;
		ALU_RRC: begin
			res.val = {cin, b[7:1]};
			res.c = b[0];
		end
		ALU_RLC: begin
			res.val = {b[6:0], cin};
			res.c = b[7];
		end
		ALU_SWAP: res.val = {b[3:0], b[7:4]};
		ALU_DAA: begin
			if (a[3:0] > 4'h9 || dcin) begin
				adj = adj + 9'h006;
			end
			if (adj[7:4] > 4'h9 || cin || adj[8]) begin
				adj = adj + 9'h060;
			end
			res.val = adj[7:0];
			res.c = adj[8] | cin;
		end
		default:  res.val = b;
		endcase
		res.z = (res.val == 8'h00);
	end
endmodule : idc_alu
`default_nettype wire

// ---- design/idc_stack.sv ----
/*
 * Eight-level return address stack, wrapping circularly.
 * Assumes push and pop never arrive in the same cycle.
 */
`default_nettype none
module idc_stack (
	// Clock and reset
	input  wire logic           clk,
	input  wire logic           sys_rst,
	// Stack operations
	input  wire logic           push,
	input  wire logic           pop,
	input  wire idc_pkg::idc_pc_t push_data,
	output idc_pkg::idc_pc_t    top
);
	import idc_pkg::*;
	idc_stack_t s_r;
	idc_stack_t s_nxt;

	// Top of stack is the slot below the pointer
	assign top = s_r.slot[s_r.ptr - 3'h1];

	// Next-state of pointer and slots
	always_comb begin
		s_nxt = s_r;
		if (push) begin
			s_nxt.slot[s_r.ptr] = push_data;
			s_nxt.ptr = s_r.ptr + 3'h1;
		end else if (pop) begin
			s_nxt.ptr = s_r.ptr - 3'h1;
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
endmodule : idc_stack
`default_nettype wire

// ---- design/idc_core.sv ----
/*
 * Instruction decode and execute control of the 8-bit core.
 * Assumes asynchronous-read program memory, register file and control
 * registers; writes to them are presented for one clk cycle.
 */
// What this block does
// - Each instruction is one 13-bit word: opcode field plus operand fields.
// - An instruction cycle is two clocks; ordinary instructions take one cycle.
// - Instructions that alter the program counter take two instruction cycles.
// - Any register bit can be set, cleared or tested by one instruction; status T and P can only be tested.
// - I/O registers are reached by the same register-operand instructions.
// - Literals are 8 bits for data, 10 bits for jump and call targets.
// - Power-down opcode clears watchdog, stops execution, updates T and P.
// - Watchdog-clear opcode clears watchdog, keeps running, updates T and P.
// - Control register write/read moves accumulator via low four bits.
// - Enable, disable interrupts; return-from-interrupt pops and enables.
// - Prescaler control register copied to/from accumulator, no flag change.
// - Table offset adds accumulator to counter low byte; updates Z, C, DC.
// - Register ops use a 6-bit field; direction bit picks destination.
// - Decrement/increment-and-skip write result, skip on zero, no flags.
// - Rotates go through carry in either direction.
// - Nibble exchange swaps halves into accumulator or register, no flags.
// - Bit ops: 3-bit bit number, clear, set, skip-if-low, skip-if-high.
// - Call pushes next address and loads page plus literal; jump loads only.
// - Literal ops load, OR, AND, XOR, subtract, add; return-literal pops.
// - Software interrupt pushes next address and jumps to address one.
// - Decimal adjust corrects accumulator and updates only carry.
`default_nettype none
module idc_core (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              sys_rst,
	// Program memory
	output idc_pkg::idc_pc_t       pm_addr,
	input  wire idc_pkg::idc_instr_t pm_data,
	// Register file
	output logic [5:0]             reg_raddr,
	input  wire idc_pkg::idc_data_t reg_rdata,
	output logic                   reg_we,
	output logic [5:0]             reg_waddr,
	output idc_pkg::idc_data_t     reg_wdata,
	// Control registers
	output logic [3:0]             ctl_raddr,
	input  wire idc_pkg::idc_data_t ctl_rdata,
	output logic                   ctl_we,
	output logic [3:0]             ctl_waddr,
	output idc_pkg::idc_data_t     ctl_wdata,
	// System signals
	output logic                   wdt_clr,
	output logic                   irq_en,
	output idc_pkg::idc_data_t     presc_ctrl,
	output logic                   power_down,
	input  wire logic              wake_pin,
	// Debug register port
	input  wire logic [2:0]        dbg_addr,
	input  wire idc_pkg::idc_data_t dbg_wdata,
	input  wire logic              dbg_wr,
	input  wire logic              dbg_rd,
	output idc_pkg::idc_data_t     dbg_rdata
);
	import idc_pkg::*;

	localparam idc_core_t CORE_RESET = '{
		phase: 1'b0, ir: '0, pc: PC_RESET, acc: 8'h00,
		st: STATUS_RESET, ie: 1'b0, presc: PRESC_RESET, sleep: 1'b0,
		skip: 1'b0, bubble: 1'b0, run: RUN_RESET, reg_we: 1'b0,
		reg_waddr: 6'h00, reg_wdata: 8'h00, ctl_we: 1'b0,
		ctl_waddr: 4'h0, ctl_wdata: 8'h00, wdt_clr: 1'b0,
		rdata: 8'h00, wake_sync: 3'h0
	};

	idc_core_t    s_r;
	idc_core_t    s_nxt;
	idc_alu_op_t  alu_op;
	idc_data_t    alu_b;
	idc_alu_res_t alu_res;
	idc_data_t    opnd;
	idc_pc_t      stk_top;
	idc_pc_t      push_data;
	logic         push;
	logic         pop;
	logic         wake;

	// Maps the 4-bit register-op group to its ALU operation
	function automatic idc_alu_op_t reg_group_op(input logic [3:0] g);
		case (g)
		4'h2:       reg_group_op = ALU_SUB;
		4'h4:       reg_group_op = ALU_OR;
		4'h5:       reg_group_op = ALU_AND;
		4'h6:       reg_group_op = ALU_XOR;
		4'h7:       reg_group_op = ALU_ADD;
		4'h8:       reg_group_op = ALU_PASS;
		4'h9:       reg_group_op = ALU_COM;
		4'hA, 4'hF: reg_group_op = ALU_INC;
		4'h3, 4'hB: reg_group_op = ALU_DEC;
		4'hC:       reg_group_op = ALU_RRC;
		4'hD:       reg_group_op = ALU_RLC;
		4'hE:       reg_group_op = ALU_SWAP;
		default:    reg_group_op = ALU_PASS;
		endcase
	endfunction : reg_group_op

	// Outputs straight from state
	assign pm_addr    = s_r.pc;
	assign reg_raddr  = s_r.ir[5:0];
	assign ctl_raddr  = s_r.ir[3:0];
	assign reg_we     = s_r.reg_we;
	assign reg_waddr  = s_r.reg_waddr;
	assign reg_wdata  = s_r.reg_wdata;
	assign ctl_we     = s_r.ctl_we;
	assign ctl_waddr  = s_r.ctl_waddr;
	assign ctl_wdata  = s_r.ctl_wdata;
	assign wdt_clr    = s_r.wdt_clr;
	assign irq_en     = s_r.ie;
	assign presc_ctrl = s_r.presc;
	assign power_down = s_r.sleep;
	assign dbg_rdata  = s_r.rdata;

	// Wake counts once the second and third sync stages are both high
	assign wake = s_r.wake_sync[1] & s_r.wake_sync[2];

	// Counter and status appear inside the register space
	always_comb begin
		case (s_r.ir[5:0])
		ADDR_PC:     opnd = s_r.pc[7:0];
		ADDR_STATUS: opnd = s_r.st;
		default:     opnd = reg_rdata;
		endcase
	end

	idc_alu u_alu (
		.op   (alu_op),
		.a    (s_r.acc),
		.b    (alu_b),
		.cin  (s_r.st.c),
		.dcin (s_r.st.dc),
		.res  (alu_res)
	);

	idc_stack u_stack (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.push      (push),
		.pop       (pop),
		.push_data (push_data),
		.top       (stk_top)
	);

	// Fetch, decode and execute
	always_comb begin
		logic        wr_reg;
		logic        wr_acc;
		logic        fz;
		logic        fc;
		logic        fdc;
		logic        chg_pc;
		idc_data_t   res;
		idc_data_t   mask;
		idc_pc_t     pc_inc;
		wr_reg = 1'b0;
		wr_acc = 1'b0;
		fz = 1'b0;
		fc = 1'b0;
		fdc = 1'b0;
		chg_pc = 1'b0;
		res = alu_res.val;
		mask = 8'h01 << s_r.ir[8:6];
		pc_inc = s_r.pc + 12'h001;
		s_nxt = s_r;
		push = 1'b0;
		pop = 1'b0;
		push_data = pc_inc;
		alu_op = ALU_PASS;
		alu_b = opnd;
		s_nxt.reg_we = 1'b0;
		s_nxt.ctl_we = 1'b0;
		s_nxt.wdt_clr = 1'b0;
		s_nxt.wake_sync = {s_r.wake_sync[1:0], wake_pin};
		s_nxt.phase = ~s_r.phase;
		if (!s_r.phase) begin
			s_nxt.ir = pm_data;
		end else if (s_r.run && !s_r.sleep) begin
			s_nxt.pc = pc_inc;
			if (s_r.bubble) begin
				s_nxt.bubble = 1'b0;
				s_nxt.pc = s_r.pc;
			end else if (s_r.skip) begin
				s_nxt.skip = 1'b0;
			end else begin
				casez (s_r.ir)
				13'h0000: ;
				13'h0001: begin
					alu_op = ALU_DAA;
					wr_acc = 1'b1;
					fc = 1'b1;
				end
				13'h0002: s_nxt.presc = s_r.acc;
				13'h0003: begin
					s_nxt.wdt_clr = 1'b1;
					s_nxt.sleep = 1'b1;
					s_nxt.st.t = 1'b1;
					s_nxt.st.p = 1'b0;
				end
				13'h0004: begin
					s_nxt.wdt_clr = 1'b1;
					s_nxt.st.t = 1'b1;
					s_nxt.st.p = 1'b1;
				end
				13'b0_0000_0000_????: begin
					s_nxt.ctl_we = 1'b1;
					s_nxt.ctl_waddr = s_r.ir[3:0];
					s_nxt.ctl_wdata = s_r.acc;
				end
				13'h0010: s_nxt.ie = 1'b1;
				13'h0011: s_nxt.ie = 1'b0;
				13'h0012, 13'h0013: begin
					pop = 1'b1;
					s_nxt.pc = stk_top;
					chg_pc = 1'b1;
					s_nxt.ie = s_r.ie | s_r.ir[0];
				end
				13'h0014: s_nxt.acc = s_r.presc;
				13'b0_0000_0001_????: s_nxt.acc = ctl_rdata;
				13'h0020: begin
					alu_op = ALU_ADD;
					alu_b = s_r.pc[7:0];
					s_nxt.pc = {s_r.pc[11:8], alu_res.val};
					chg_pc = 1'b1;
					{fz, fc, fdc} = 3'b111;
				end
				13'b0_0000_01??_????: begin
					res = s_r.acc;
					wr_reg = 1'b1;
				end
				13'b0_0000_1000_0000: begin
					alu_b = 8'h00;
					wr_acc = 1'b1;
					fz = 1'b1;
				end
				13'b0_0000_11??_????: begin
					alu_b = 8'h00;
					wr_reg = 1'b1;
					fz = 1'b1;
				end
				13'b0_0000_????_????: ;
				13'b0_0???_????_????: begin
					alu_op = reg_group_op(s_r.ir[10:7]);
					wr_reg = s_r.ir[6];
					wr_acc = ~s_r.ir[6];
					fz = 1'b1;
					case (s_r.ir[10:7])
					4'h2, 4'h7: {fc, fdc} = 2'b11;
					4'hB, 4'hF: begin
						fz = 1'b0;
						s_nxt.skip = alu_res.z;
					end
					4'hC, 4'hD: {fz, fc} = 2'b01;
					4'hE:       fz = 1'b0;
					default:    ;
					endcase
				end
				13'b0_100?_????_????: begin
					res = opnd & ~mask;
					wr_reg = 1'b1;
				end
				13'b0_101?_????_????: begin
					res = opnd | mask;
					wr_reg = 1'b1;
				end
				13'b0_11??_????_????: begin
					s_nxt.skip = ((opnd & mask) != 8'h00) == s_r.ir[9];
				end
				13'b1_0???_????_????: begin
					push = ~s_r.ir[10];
					s_nxt.pc = {s_r.st.gp[1:0], s_r.ir[9:0]};
					chg_pc = 1'b1;
				end
				13'b1_1100_????_????: begin
					s_nxt.acc = s_r.ir[7:0];
					pop = 1'b1;
					s_nxt.pc = stk_top;
					chg_pc = 1'b1;
				end
				13'h1E01: begin
					push = 1'b1;
					s_nxt.pc = SOFT_VECTOR;
					chg_pc = 1'b1;
				end
				13'b1_1???_????_????: begin
					alu_b = s_r.ir[7:0];
					case (s_r.ir[10:8])
					3'h1: alu_op = ALU_OR;
					3'h2: alu_op = ALU_AND;
					3'h3: alu_op = ALU_XOR;
					3'h5: alu_op = ALU_SUB;
					3'h7: alu_op = ALU_ADD;
					default: alu_op = ALU_PASS;
					endcase
					fz = (s_r.ir[10:8] != 3'h0) && (s_r.ir[10:8] != 3'h6);
					wr_acc = (s_r.ir[10:8] != 3'h6);
					{fc, fdc} = {2{s_r.ir[8] & s_r.ir[10]}};
				end
				default: ;
				endcase
				if (wr_acc) begin
					s_nxt.acc = res;
				end
				if (wr_reg) begin
					if (s_r.ir[5:0] == ADDR_PC) begin
						s_nxt.pc = {s_r.pc[11:8], res};
						chg_pc = 1'b1;
					end else if (s_r.ir[5:0] == ADDR_STATUS) begin
						s_nxt.st.gp = res[7:5];
						{s_nxt.st.z, s_nxt.st.dc, s_nxt.st.c} = res[2:0];
					end else begin
						s_nxt.reg_we = 1'b1;
						s_nxt.reg_waddr = s_r.ir[5:0];
						s_nxt.reg_wdata = res;
					end
				end
				if (fz) begin
					s_nxt.st.z = alu_res.z;
				end
				if (fc) begin
					s_nxt.st.c = alu_res.c;
				end
				if (fdc) begin
					s_nxt.st.dc = alu_res.dc;
				end
				s_nxt.bubble = chg_pc;
			end
		end
		// Wake from power-down by pin
		if (s_r.sleep && wake) begin
			s_nxt.sleep = 1'b0;
		end
		// Debug port write: bit 0 runs, bit 1 wakes
		if (dbg_wr && dbg_addr == DBG_CTRL) begin
			s_nxt.run = dbg_wdata[0];
			if (dbg_wdata[1] && s_r.sleep) begin
				s_nxt.sleep = 1'b0;
			end
		end
		// Debug port read, answered in the next cycle
		if (dbg_rd) begin
			case (dbg_addr)
			DBG_CTRL:   s_nxt.rdata = {6'h00, s_r.sleep, s_r.run};
			DBG_ACC:    s_nxt.rdata = s_r.acc;
			DBG_PCL:    s_nxt.rdata = s_r.pc[7:0];
			DBG_STATUS: s_nxt.rdata = s_r.st;
			DBG_PCH:    s_nxt.rdata = {4'h0, s_r.pc[11:8]};
			default:    s_nxt.rdata = 8'h00;
			endcase
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_r <= CORE_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end
endmodule : idc_core
`default_nettype wire

// ---- testbench/idc_mem_model.sv ----
/*
 * Program memory, register file and control registers seen by the core.
 * Assumes the bench loads the program image before reset is released.
 */
`default_nettype none
module idc_mem_model (
	// Clock
	input  wire logic                clk,
	// Program memory
	input  wire idc_pkg::idc_pc_t    pm_addr,
	output idc_pkg::idc_instr_t      pm_data,
	// Register file
	input  wire logic [5:0]          reg_raddr,
	output idc_pkg::idc_data_t       reg_rdata,
	input  wire logic                reg_we,
	input  wire logic [5:0]          reg_waddr,
	input  wire idc_pkg::idc_data_t  reg_wdata,
	// Control registers
	input  wire logic [3:0]          ctl_raddr,
	output idc_pkg::idc_data_t       ctl_rdata,
	input  wire logic                ctl_we,
	input  wire logic [3:0]          ctl_waddr,
	input  wire idc_pkg::idc_data_t  ctl_wdata
);
	timeunit 1ns;
	timeprecision 100ps;
	import idc_pkg::*;
	idc_instr_t rom [4096];
	idc_data_t  rf  [64];
	idc_data_t  ctl [16];
	// Asynchronous reads of whole 13-bit words and 8-bit registers
	assign pm_data   = rom[pm_addr];
	assign reg_rdata = rf[reg_raddr];
	assign ctl_rdata = ctl[ctl_raddr];
	// Writes land on the edge that ends the write pulse
	always @(posedge clk) begin
		if (reg_we) rf[reg_waddr] <= reg_wdata;
		if (ctl_we) ctl[ctl_waddr] <= ctl_wdata;
	end
endmodule : idc_mem_model
`default_nettype wire

// ---- testbench/idc_core_sva.sv ----
/*
 * Port-level checks of the decoder core.
 * Assumes one clock clk and synchronous active-high reset sys_rst.
 */
`default_nettype none
module idc_core_sva (
	// Clock and reset
	input wire logic             clk,
	input wire logic             sys_rst,
	// Program and register side
	input wire idc_pkg::idc_pc_t pm_addr,
	input wire logic [5:0]       reg_raddr,
	input wire logic             reg_we,
	input wire logic [5:0]       reg_waddr,
	input wire logic [3:0]       ctl_raddr,
	input wire logic             ctl_we,
	input wire logic [3:0]       ctl_waddr,
	// System outputs
	input wire logic             wdt_clr,
	input wire logic             power_down
);
	timeunit 1ns;
	timeprecision 100ps;
	import idc_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Counter moved somewhere other than the next word
	sequence s_branch;
		$changed(pm_addr) && (pm_addr != $past(pm_addr) + 12'h001);
	endsequence
	// Dead instruction cycle plus the fetch of the target
	sequence s_dead;
		$stable(pm_addr) [*3];
	endsequence
	pc_pace_a: assert property ($changed(pm_addr) |=> $stable(pm_addr))
		else $error("program counter changed two cycles running");
	branch_wait_a: assert property (s_branch |=> s_dead)
		else $error("branch without dead cycle");
	reg_pulse_a: assert property (reg_we |=> !reg_we)
		else $error("register write longer than one cycle");
	reg_dest_a: assert property (reg_we |-> reg_waddr == reg_raddr)
		else $error("register write to wrong address");
	ctl_dest_a: assert property (ctl_we |-> ctl_waddr == ctl_raddr)
		else $error("control write to wrong address");
	wdt_pulse_a: assert property (wdt_clr |=> !wdt_clr)
		else $error("watchdog clear longer than one cycle");
	wdt_alone_a: assert property (wdt_clr |-> !reg_we && !ctl_we)
		else $error("watchdog clear with a register write");
	sleep_clr_a: assert property ($rose(power_down) |-> wdt_clr)
		else $error("power-down without watchdog clear");
	sleep_hold_a: assert property (
		power_down && $past(power_down) |-> $stable(pm_addr))
		else $error("counter moved while powered down");
endmodule : idc_core_sva

bind idc_core idc_core_sva i_idc_core_sva (
	.clk(clk), .sys_rst(sys_rst), .pm_addr(pm_addr),
	.reg_raddr(reg_raddr), .reg_we(reg_we), .reg_waddr(reg_waddr),
	.ctl_raddr(ctl_raddr), .ctl_we(ctl_we), .ctl_waddr(ctl_waddr),
	.wdt_clr(wdt_clr), .power_down(power_down)
);
`default_nettype wire

// ---- testbench/testbench.sv ----
/*
 * Self-checking bench: runs a small program in stops ended by power-down.
 * Assumes the core resumes after the power-down word when woken.
 */
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	import idc_pkg::*;
	logic clk, sys_rst, wake_pin, dbg_wr, dbg_rd;
	logic reg_we, ctl_we, wdt_clr, irq_en, power_down;
	logic [2:0] dbg_addr;
	logic [5:0] reg_raddr, reg_waddr;
	logic [3:0] ctl_raddr, ctl_waddr;
	idc_pc_t    pm_addr;
	idc_instr_t pm_data;
	idc_data_t  reg_rdata, reg_wdata, ctl_rdata, ctl_wdata;
	idc_data_t  presc_ctrl, dbg_wdata, dbg_rdata;
	int         err_count, num_checks;
	// Program image: stops at words 2, 11, 14 and again at 2 after the trap
	localparam logic [12:0] PROG [18] = '{
		13'h183C, 13'h1FD9, 13'h0003, 13'h0050, 13'h07D1, 13'h0550,
		13'h0BD0, 13'h0710, 13'h0006, 13'h0002, 13'h0004, 13'h0003,
		13'h0010, 13'h1020, 13'h0003, 13'h0011, 13'h003F, 13'h1E01};
	// Subroutine at word 0x20: decimal adjust, rotate, bit ops, subtract
	localparam logic [12:0] SUBR [14] = '{
		13'h1838, 13'h1F45, 13'h0001, 13'h0054, 13'h0052, 13'h06D2,
		13'h0852, 13'h0C52, 13'h00D2, 13'h0E92, 13'h00D2, 13'h0112,
		13'h0053, 13'h1C77};

	idc_core i_idc_core (.clk(clk), .sys_rst(sys_rst), .pm_addr(pm_addr),
		.pm_data(pm_data), .reg_raddr(reg_raddr), .reg_rdata(reg_rdata),
		.reg_we(reg_we), .reg_waddr(reg_waddr), .reg_wdata(reg_wdata),
		.ctl_raddr(ctl_raddr), .ctl_rdata(ctl_rdata), .ctl_we(ctl_we),
		.ctl_waddr(ctl_waddr), .ctl_wdata(ctl_wdata), .wdt_clr(wdt_clr),
		.irq_en(irq_en), .presc_ctrl(presc_ctrl), .power_down(power_down),
		.wake_pin(wake_pin), .dbg_addr(dbg_addr), .dbg_wdata(dbg_wdata),
		.dbg_wr(dbg_wr), .dbg_rd(dbg_rd), .dbg_rdata(dbg_rdata));
	idc_mem_model i_idc_mem_model (.clk(clk), .pm_addr(pm_addr),
		.pm_data(pm_data), .reg_raddr(reg_raddr), .reg_rdata(reg_rdata),
		.reg_we(reg_we), .reg_waddr(reg_waddr), .reg_wdata(reg_wdata),
		.ctl_raddr(ctl_raddr), .ctl_rdata(ctl_rdata), .ctl_we(ctl_we),
		.ctl_waddr(ctl_waddr), .ctl_wdata(ctl_wdata));

	// 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Verdict and end of run
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : close_out

	task automatic chk_byte(input idc_data_t got, exp, input string m);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t %s got %h want %h", $time, m, got, exp);
		end
	endtask : chk_byte

	task automatic chk_bit(input logic got, exp, input string m);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t %s got %b want %b", $time, m, got, exp);
		end
	endtask : chk_bit

	// Debug port read: data stands in the cycle after the strobe
	task automatic dbg_read(input logic [2:0] a, input idc_data_t exp,
		input string m);
		@(posedge clk);
		dbg_rd   <= 1'b1;
		dbg_addr <= a;
		@(posedge clk);
		dbg_rd   <= 1'b0;
		#1 chk_byte(dbg_rdata, exp, m);
	endtask : dbg_read

	task automatic dbg_write(input logic [2:0] a, input idc_data_t d);
		@(posedge clk);
		dbg_wr    <= 1'b1;
		dbg_addr  <= a;
		dbg_wdata <= d;
		@(posedge clk);
		dbg_wr    <= 1'b0;
	endtask : dbg_write

	// Bounded wait for the power-down level to reach v
	task automatic wait_pd(input logic v);
		int n;
		n = 0;
		while (power_down !== v && n < 400) begin
			@(posedge clk);
			n++;
		end
		if (power_down !== v) begin
			err_count++;
			$display("BAD %0t power-down level never reached", $time);
			close_out();
		end
	endtask : wait_pd

	initial begin
		err_count = 0;
		num_checks = 0;
		sys_rst = 1'b1;
		wake_pin = 1'b0;
		dbg_wr = 1'b0;
		dbg_rd = 1'b0;
		dbg_addr = 3'h0;
		dbg_wdata = 8'h00;
		// Image and preset registers; no store to interrupt status
		for (int i = 0; i < 4096; i++) begin
			i_idc_mem_model.rom[i] = (i < 18) ? PROG[i] : 13'h0000;
		end
		for (int i = 0; i < 14; i++) begin
			i_idc_mem_model.rom[12'h020 + i] = SUBR[i];
		end
		i_idc_mem_model.rf[6'h11] = 8'hFF;
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		#1 chk_byte(presc_ctrl, PRESC_RESET, "presc reset");
		chk_bit(irq_en, 1'b0, "irq reset");
		// Stop 1: literal load and add
		wait_pd(1'b1);
		dbg_read(DBG_ACC, 8'h15, "add acc");
		dbg_read(DBG_STATUS, 8'h13, "add flags");
		dbg_read(3'h5, 8'h00, "unmapped read");
		@(posedge clk);
		wake_pin <= 1'b1;
		wait_pd(1'b0);
		@(posedge clk);
		wake_pin <= 1'b0;
		// Stop 2: store, skip, bit set, swap, control writes
		wait_pd(1'b1);
		dbg_read(DBG_ACC, 8'h59, "swap acc");
		chk_byte(i_idc_mem_model.rf[6'h10], 8'h95, "bit set");
		chk_byte(i_idc_mem_model.rf[6'h11], 8'h00, "inc skip");
		chk_byte(i_idc_mem_model.ctl[4'h6], 8'h59, "ctl write");
		chk_byte(presc_ctrl, 8'h59, "presc write");
		dbg_read(DBG_STATUS, 8'h13, "no flag ops");
		dbg_write(DBG_CTRL, 8'h03);
		// Stop 3: enable, call and literal return
		wait_pd(1'b0);
		wait_pd(1'b1);
		dbg_read(DBG_ACC, 8'h77, "literal return");
		dbg_read(DBG_PCL, 8'h0F, "return address");
		dbg_read(DBG_STATUS, 8'h12, "sub flags");
		chk_byte(i_idc_mem_model.rf[6'h14], 8'h83, "bcd adjust");
		chk_byte(i_idc_mem_model.rf[6'h12], 8'h04, "rot bits");
		chk_byte(i_idc_mem_model.rf[6'h13], 8'h81, "subtract");
		chk_bit(irq_en, 1'b1, "irq enabled");
		dbg_write(DBG_CTRL, 8'h03);
		// Stop 4: disable, unknown word, software trap to word 1
		wait_pd(1'b0);
		wait_pd(1'b1);
		dbg_read(DBG_ACC, 8'h50, "trap add");
		dbg_read(DBG_PCL, 8'h03, "trap vector");
		dbg_read(DBG_STATUS, 8'h13, "trap flags");
		chk_bit(irq_en, 1'b0, "irq disabled");
		close_out();
	end
endmodule : testbench
`default_nettype wire
